// [src/cie_core_exec.v]
// Instruction execution subset with Wishbone register access
`timescale 1ns/1ps
`include "cie_map.vh"

module cie_core_exec (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output wire        wb_ack_o,
	output wire        busy_o
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_EXEC  = 2'h1;
	localparam ST_CALL2 = 2'h2;

	localparam [3:0] K_NONE = 4'h0;
	localparam [3:0] K_CALL = 4'h1;
	localparam [3:0] K_COM  = 4'h2;
	localparam [3:0] K_CLEAR_FILE_OP = 4'h3;
	localparam [3:0] K_CLEAR_ACCUMULATOR_OP = 4'h4;
	localparam [3:0] K_DEC  = 4'h5;
	localparam [3:0] K_SUB  = 4'h6;

	reg [1:0]                  state_reg;
	reg [`CIE_W_OPCODE-1:0]    instr_reg;
	reg [`CIE_W_DATA-1:0]      acc_reg;
	reg [`CIE_W_DATA-1:0]      status_reg;
	reg [`CIE_W_PC-1:0]        pc_reg;
	reg [`CIE_W_DATA-1:0]      latch_reg;
	reg [`CIE_W_BANK-1:0]      bank_reg;
	reg [`CIE_W_ADDR-1:0]      faddr_reg;
	reg [`CIE_W_SP-1:0]        sp_reg;
	reg [`CIE_W_PC-1:0]        stack_mem [0:`CIE_STACK_DEPTH-1];
	reg                        ack_reg;

	wire                       req;
	wire                       wr_req;
	wire                       byte0;
	wire [3:0]                 kind;
	wire [`CIE_W_ADDR-1:0]     f_addr;
	wire                       dest_file;
	wire [`CIE_W_DATA-1:0]     f_val;
	wire [`CIE_W_DATA-1:0]     bus_f_val;
	reg  [`CIE_W_DATA-1:0]     result;
	reg  [`CIE_W_DATA-1:0]     status_next;
	reg                        to_file;
	reg                        to_acc;
	reg  [8:0]                 diff9;
	reg  [4:0]                 diff5;

	assign req    = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr_req = req && wb_we_i;
	assign byte0  = wb_sel_i[0];
	assign busy_o = (state_reg != ST_IDLE);
	assign wb_ack_o = ack_reg;

	// Classify an opcode into one of the supported operations
	function [3:0] op_kind;
		input [`CIE_W_OPCODE-1:0] op;
		begin
			if (op[13:11] == `CIE_OP_CALL_HI) begin
				op_kind = K_CALL;
			end else if (op[13:12] != `CIE_OP_BYTE_HI) begin
				op_kind = K_NONE;
			end else if (op[11:8] == `CIE_OP_COM) begin
				op_kind = K_COM;
			end else if (op[11:8] == `CIE_OP_DEC) begin
				op_kind = K_DEC;
			end else if (op[11:8] == `CIE_OP_SUB) begin
				op_kind = K_SUB;
			end else if (op[11:8] == `CIE_OP_CLR) begin
				op_kind = op[`CIE_CLEAR_FILE_OP_BIT] ? K_CLEAR_FILE_OP : K_CLEAR_ACCUMULATOR_OP;
			end else begin
				op_kind = K_NONE;
			end
		end
	endfunction

	function [`CIE_W_DATA-1:0] set_z;
		input [`CIE_W_DATA-1:0] st;
		input [`CIE_W_DATA-1:0] val;
		begin
			set_z = st;
			set_z[`CIE_STATUS_Z] = (val == 8'h00);
		end
	endfunction

	assign kind = op_kind(instr_reg);
	// Operand is a bank-relative 7-bit address
	// bank relative address
	assign f_addr    = instr_reg[`CIE_W_ADDR-1:0];
	assign dest_file = instr_reg[`CIE_D_BIT];

	cie_file_ram cie_file_ram_i (
		.clk_i     (clk_i),
		.a_addr_i  ({bank_reg, f_addr}),
		.a_we_i    (to_file),
		.a_wdata_i (result),
		.a_rdata_o (f_val),
		.b_addr_i  ({bank_reg, faddr_reg}),
		.b_we_i    (wr_req && byte0 && (wb_adr_i == `CIE_REG_FILE) && !busy_o),
		.b_wdata_i (wb_dat_i[7:0]),
		.b_rdata_o (bus_f_val)
	);

	always @* begin
		result      = 8'h00;
		status_next = status_reg;
		to_file     = 1'b0;
		to_acc      = 1'b0;
		diff9       = {1'b0, f_val} - {1'b0, acc_reg};
		diff5       = {1'b0, f_val[3:0]} - {1'b0, acc_reg[3:0]};
		if (state_reg == ST_EXEC) begin
			case (kind)
				K_COM: begin
					result      = ~f_val;
					status_next = set_z(status_reg, result);
				end
				K_CLEAR_FILE_OP: begin
					result      = 8'h00;
					status_next = set_z(status_reg, 8'h00);
				end
				K_CLEAR_ACCUMULATOR_OP: begin
					result      = 8'h00;
					status_next = set_z(status_reg, 8'h00);
				end
				K_DEC: begin
					result      = f_val - 8'h01;
					status_next = set_z(status_reg, result);
				end
				K_SUB: begin
					result      = diff9[7:0];
					status_next = set_z(status_reg, result);
					status_next[`CIE_STATUS_C] = !diff9[8];
					status_next[`CIE_STATUS_NC] = !diff5[4];
				end
				default: begin
					status_next = status_reg;
				end
			endcase
			if (kind == K_CLEAR_FILE_OP) begin
				to_file = 1'b1;
			end else if (kind == K_CLEAR_ACCUMULATOR_OP) begin
				to_acc = 1'b1;
			end else if (kind == K_COM || kind == K_DEC || kind == K_SUB) begin
				to_file = dest_file;
				to_acc  = !dest_file;
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg  <= ST_IDLE;
			instr_reg  <= 14'h0000;
			acc_reg    <= `CIE_ACC_RST;
			status_reg <= `CIE_STATUS_RST;
			pc_reg     <= `CIE_PC_RST;
			latch_reg  <= `CIE_LATCH_RST;
			bank_reg   <= `CIE_BANK_RST;
			faddr_reg  <= 7'h00;
			sp_reg     <= 3'h0;
			ack_reg    <= 1'b0;
		end else begin
			ack_reg <= req;
			case (state_reg)
				ST_IDLE: begin
					if (wr_req && (wb_adr_i == `CIE_REG_INSTR) && (&wb_sel_i[1:0])) begin
						instr_reg <= wb_dat_i[13:0];
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					status_reg <= status_next;
					if (to_acc) begin
						acc_reg <= result;
					end
					if (kind == K_CALL) begin
						stack_mem[sp_reg] <= pc_reg + 13'h0001;
						sp_reg            <= sp_reg + 3'h1;
						state_reg         <= ST_CALL2;
					end else begin
						pc_reg    <= pc_reg + 13'h0001;
						state_reg <= ST_IDLE;
					end
				end
				ST_CALL2: begin
					pc_reg[10:0]  <= instr_reg[10:0];
					pc_reg[12:11] <= latch_reg[`CIE_LATCH_HI_BIT:`CIE_LATCH_LO_BIT];
					state_reg     <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
			// Software writes are ignored while an instruction runs
			if (wr_req && !busy_o && byte0) begin
				if (wb_adr_i == `CIE_REG_ACC) begin
					acc_reg <= wb_dat_i[7:0];
				end else if (wb_adr_i == `CIE_REG_STATUS) begin
					status_reg <= wb_dat_i[7:0];
				end else if (wb_adr_i == `CIE_REG_LATCH) begin
					latch_reg <= wb_dat_i[7:0];
				end else if (wb_adr_i == `CIE_REG_BANK) begin
					bank_reg <= wb_dat_i[1:0];
				end else if (wb_adr_i == `CIE_REG_FADDR) begin
					faddr_reg <= wb_dat_i[6:0];
				end else if (wb_adr_i == `CIE_REG_SP) begin
					sp_reg <= wb_dat_i[2:0];
				end
			end
			if (wr_req && !busy_o && (wb_adr_i == `CIE_REG_PC) && (&wb_sel_i[1:0])) begin
				pc_reg <= wb_dat_i[12:0];
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req && !wb_we_i) begin
			if (wb_adr_i == `CIE_REG_INSTR) begin
				wb_dat_o <= {18'h00000, instr_reg};
			end else if (wb_adr_i == `CIE_REG_ACC) begin
				wb_dat_o <= {24'h000000, acc_reg};
			end else if (wb_adr_i == `CIE_REG_STATUS) begin
				wb_dat_o <= {24'h000000, status_reg};
			end else if (wb_adr_i == `CIE_REG_PC) begin
				wb_dat_o <= {19'h00000, pc_reg};
			end else if (wb_adr_i == `CIE_REG_LATCH) begin
				wb_dat_o <= {24'h000000, latch_reg};
			end else if (wb_adr_i == `CIE_REG_BANK) begin
				wb_dat_o <= {30'h00000000, bank_reg};
			end else if (wb_adr_i == `CIE_REG_FILE) begin
				wb_dat_o <= {24'h000000, bus_f_val};
			end else if (wb_adr_i == `CIE_REG_FADDR) begin
				wb_dat_o <= {25'h0000000, faddr_reg};
			end else if (wb_adr_i == `CIE_REG_SP) begin
				wb_dat_o <= {29'h00000000, sp_reg};
			end else if (wb_adr_i == `CIE_REG_STACK_TOP) begin
				wb_dat_o <= {19'h00000, stack_mem[sp_reg - 3'h1]};
			end else if (wb_adr_i == `CIE_REG_BUSY) begin
				wb_dat_o <= {31'h00000000, busy_o};
			end else begin
				wb_dat_o <= 32'h00000000;
			end
		end
	end

endmodule

// [src/cie_file_ram.v]
// Data memory: four banks of 128 bytes with two access ports
`timescale 1ns/1ps
`include "cie_map.vh"

module cie_file_ram (
	input  wire                          clk_i,
	input  wire [`CIE_W_BANK+`CIE_W_ADDR-1:0] a_addr_i,
	input  wire                          a_we_i,
	input  wire [`CIE_W_DATA-1:0]        a_wdata_i,
	output wire [`CIE_W_DATA-1:0]        a_rdata_o,
	input  wire [`CIE_W_BANK+`CIE_W_ADDR-1:0] b_addr_i,
	input  wire                          b_we_i,
	input  wire [`CIE_W_DATA-1:0]        b_wdata_i,
	output wire [`CIE_W_DATA-1:0]        b_rdata_o
);

	reg [`CIE_W_DATA-1:0] mem [0:(1<<(`CIE_W_BANK+`CIE_W_ADDR))-1];

	// Port a wins when both write one location
	always @(posedge clk_i) begin
		if (a_we_i) begin
			mem[a_addr_i] <= a_wdata_i;
		end
		if (b_we_i && !(a_we_i && (a_addr_i == b_addr_i))) begin
			mem[b_addr_i] <= b_wdata_i;
		end
	end

	assign a_rdata_o = mem[a_addr_i];
	assign b_rdata_o = mem[b_addr_i];

endmodule

// [src/cie_map.vh]
// Constants for the core instruction execution subset
`ifndef CIE_MAP_VH
`define CIE_MAP_VH

`define CIE_W_DATA        8
`define CIE_W_PC          13
`define CIE_W_ADDR        7
`define CIE_W_BANK        2
`define CIE_W_OPCODE      14
`define CIE_STACK_DEPTH   8
`define CIE_W_SP          3

// Opcode patterns (14-bit words)
`define CIE_OP_CALL_HI    3'h4
`define CIE_OP_BYTE_HI    2'h0
`define CIE_OP_SUB        4'h2
`define CIE_OP_DEC        4'h3
`define CIE_OP_CLR        4'h1
`define CIE_OP_COM        4'h9

// Field positions
`define CIE_D_BIT         7
`define CIE_CLEAR_FILE_OP_BIT      7
`define CIE_LATCH_HI_BIT  4
`define CIE_LATCH_LO_BIT  3

// Status bit positions and reset values
`define CIE_STATUS_C      0
`define CIE_STATUS_NC     1
`define CIE_STATUS_Z      2
`define CIE_STATUS_RST    8'h00
`define CIE_ACC_RST       8'h00
`define CIE_PC_RST        13'h0000
`define CIE_LATCH_RST     8'h00
`define CIE_BANK_RST      2'h0

// Wishbone register offsets (byte addresses)
`define CIE_REG_INSTR     8'h00
`define CIE_REG_ACC       8'h04
`define CIE_REG_STATUS    8'h08
`define CIE_REG_PC        8'h0C
`define CIE_REG_LATCH     8'h10
`define CIE_REG_BANK      8'h14
`define CIE_REG_FILE      8'h18
`define CIE_REG_FADDR     8'h1C
`define CIE_REG_SP        8'h20
`define CIE_REG_STACK_TOP 8'h24
`define CIE_REG_BUSY      8'h28

// Cycles per instruction
`define CIE_CYC_CALL      2'h2
`define CIE_CYC_BYTE      2'h1

`endif

// [tb/cie_core_exec_asserts.sv]
// Port-level checks for the execution subset
`timescale 1ns/1ps
module cie_core_exec_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire iwr  = take & wb_we_i & (wb_adr_i == 8'h00) & (wb_sel_i[1:0] == 2'h3) & ~busy_o;
	sequence call_go;
		iwr && wb_dat_i[13:11] == 3'h4;
	endsequence
	sequence byte_go;
		iwr && wb_dat_i[13:12] == 2'h0;
	endsequence
	ack_after_take_a: assert property (take |=> wb_ack_o)
		else $error("ack missing after request");
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_has_req_a: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	call_two_cyc_a: assert property (call_go |=> busy_o [*2] ##1 !busy_o)
		else $error("call not two cycles");
	byte_one_cyc_a: assert property (byte_go |=> busy_o ##1 !busy_o)
		else $error("byte op not one cycle");
	busy_cause_a: assert property ($rose(busy_o) |-> $past(iwr))
		else $error("busy without instruction");
	busy_bound_a: assert property (busy_o ##1 busy_o |=> !busy_o)
		else $error("busy beyond two cycles");
	unmapped_zero_a: assert property (take && !wb_we_i && wb_adr_i == 8'h2C |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	status_upper_a: assert property (take && !wb_we_i && wb_adr_i == 8'h08
		|=> wb_dat_o[31:3] == 29'h0)
		else $error("status upper bits set");
endmodule

bind cie_core_exec cie_core_exec_chk cie_core_exec_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o);

// [tb/cie_core_exec_bench.sv]
// Register-level bench for the execution subset
`timescale 1ns/1ps
module cie_core_exec_bench;
	logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
	logic        wb_ack_o, busy_o;
	int          bad_count = 0, cmp_count = 0;
	logic [7:0]  sf [5] = '{8'h05, 8'h03, 8'h07, 8'h10, 8'h01};
	logic [7:0]  sw [5] = '{8'h03, 8'h05, 8'h07, 8'h01, 8'h10};
	logic [7:0]  sr [5] = '{8'h02, 8'hFE, 8'h00, 8'h0F, 8'hF1};
	logic [7:0]  ss [5] = '{8'h03, 8'h00, 8'h07, 8'h01, 8'h02};
	always #25 clk_i = ~clk_i;
	cie_core_exec cie_core_exec_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));
	task xfer(input [7:0] a, input logic w, input [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task chk(input [7:0] a, input [31:0] e);
		xfer(a, 1'b0, 32'h0);
		cmp_count++;
		if (rdat !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, rdat, e);
		end
	endtask
	// Instruction done within three cycles
	task ex(input [13:0] op);
		wr(8'h00, {18'h0, op});
		repeat (3) @(posedge clk_i);
	endtask
	task report_and_stop;
		$display("mismatches=%0d compares=%0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		chk(8'h0C, 32'h0);
		wr(8'h14, 2); wr(8'h1C, 8'h7F); wr(8'h18, 8'h11);
		wr(8'h14, 1); wr(8'h18, 8'h5A); wr(8'h08, 3); wr(8'h04, 8'h3C);
		ex({6'b001001, 1'b0, 7'h7F});
		chk(8'h04, 8'hA5);
		chk(8'h18, 8'h5A);
		chk(8'h08, 8'h03);
		ex({6'b001001, 1'b1, 7'h7F});
		chk(8'h18, 8'hA5);
		wr(8'h14, 2);
		chk(8'h18, 8'h11);
		wr(8'h14, 1);
		ex({7'b0000011, 7'h7F});
		chk(8'h18, 8'h00);
		chk(8'h08, 8'h07);
		ex({6'b000011, 1'b1, 7'h7F});
		chk(8'h18, 8'hFF);
		chk(8'h08, 8'h03);
		wr(8'h18, 1);
		ex({6'b000011, 1'b0, 7'h7F});
		chk(8'h04, 8'h00);
		chk(8'h08, 8'h07);
		wr(8'h04, 8'h55); wr(8'h08, 0);
		ex(14'h0100);
		chk(8'h04, 8'h00);
		chk(8'h08, 8'h04);
		for (int i = 0; i < 5; i++) begin
			wr(8'h18, sf[i]); wr(8'h04, sw[i]); wr(8'h08, 0);
			ex({6'b000010, 1'b0, 7'h7F});
			chk(8'h04, sr[i]);
			chk(8'h08, ss[i]);
		end
		wr(8'h18, 9); wr(8'h04, 4);
		ex({6'b000010, 1'b1, 7'h7F});
		chk(8'h18, 8'h05);
		chk(8'h04, 8'h04);
		wr(8'h08, 5); wr(8'h0C, 13'h0123); wr(8'h10, 8'h18);
		ex({3'b100, 11'h7FF});
		chk(8'h0C, 13'h1FFF);
		chk(8'h24, 13'h0124);
		chk(8'h20, 1);
		chk(8'h08, 5);
		wr(8'h10, 8'h08);
		ex({3'b100, 11'h005});
		chk(8'h0C, 13'h0805);
		chk(8'h24, 13'h0000);
		chk(8'h2C, 0);
		report_and_stop;
	end
endmodule
